// ---- core/bms_top.sv ----
// Behaviour
// - an eight-bit bank port, one bit for each selectable bank
// - up to two 64K rows; outside the common range and boot, each enabled only when its bank bit is set
// - each row is tied to exactly one chosen bank-port bit
// - bank-port access accepted only while IOEXP is at the chosen level
// - with no IOEXP polarity chosen, IOEXP is ignored for the port
// - memory answers only while MEMEX is at the chosen level
// - with no MEMEX polarity chosen, MEMEX is ignored
// - common on board: addresses in the common range enable row 0
// - common elsewhere: no memory here answers in the common range
// - boot option: system reset enables row 0 until the port is written
// - during boot, common range disables row 0 for the common memory
// - port address from eight straps, strapped reads 0, open reads 1
// - common end is strapped upper byte with low byte all ones
// - common start is strapped upper byte with low byte zero
// - the device never asserts a bus interrupt request
// - the common area stays enabled whatever bank is selected
// - IOEXP qualifies the port decode, MEMEX the memory row decode
// - rows are refreshed on refresh cycles even when not selected
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "bms_consts.svh"
module bms_top #(
  parameter int NUM_ROWS  = 2,
  parameter int BANK_BITS = 8
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 resetn,
  // apb slave
  input  wire logic [7:0]           paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // backplane address, data and strobes
  input  wire logic [15:0]          std_addr,
  input  wire logic [7:0]           std_data_in,
  output logic      [7:0]           std_data_out,
  output logic                      std_data_oe,
  input  wire logic                 std_rd_n,
  input  wire logic                 std_wr_n,
  input  wire logic                 std_memrq_n,
  input  wire logic                 std_iorq_n,
  input  wire logic                 std_memex,
  input  wire logic                 std_ioexp,
  input  wire logic                 std_refresh_n,
  input  wire logic                 std_sysreset_n,
  // backplane interrupt request, open drain
  output logic                      std_intrq_n_out,
  output logic                      std_intrq_n_oe,
  // memory rows
  output logic      [NUM_ROWS-1:0]  row_enable,
  output logic      [NUM_ROWS-1:0]  row_write,
  output logic      [NUM_ROWS-1:0]  row_refresh,
  output logic      [7:0]           row_wdata,
  input  wire logic [7:0]           row_rdata
);

  localparam int BUS_W = $bits(bms_pkg::bms_bus_t);

  generate
    if (NUM_ROWS < 1 || NUM_ROWS > 2) begin : g_bad_rows
      $error("bms_top supports one or two rows");
    end
    if (BANK_BITS != 8) begin : g_bad_bank
      $error("bms_top bank port must be eight bits");
    end
  endgenerate

  // register state
  logic [31:0]               cfg_qual;
  logic [31:0]               cfg_rows;
  logic [BANK_BITS-1:0]      bank;
  logic                      boot_active;
  logic                      io_wr_q;
  logic [7:0]                rdata_q;

  // synchronised bus
  bms_pkg::bms_bus_t         bus_raw;
  bms_pkg::bms_bus_t         bus;
  bms_pkg::bms_cfg_t         cfg;

  // decode wires
  logic                      apb_access;
  logic                      apb_write;
  logic                      hit_qual;
  logic                      hit_rows;
  logic                      hit_status;
  logic                      hit_any;
  logic [31:0]               strb_mask;
  logic [31:0]               status_word;
  logic [7:0]                port_addr;
  logic                      io_wr;
  logic                      io_wr_start;
  logic                      port_qual;
  logic                      port_write;
  logic                      sys_reset;
  logic                      mem_cycle;
  logic                      mem_read;
  logic                      mem_write;
  logic                      refresh_cycle;
  logic [NUM_ROWS-1:0]       row_hit;
  logic [NUM_ROWS-1:0]       present;
  logic                      in_common;
  logic                      board_ok;
  logic [NUM_ROWS-1:0]       next_row_enable;
  logic [NUM_ROWS-1:0]       next_row_write;
  logic [NUM_ROWS-1:0]       next_row_refresh;
  logic                      next_data_oe;

  // backplane inputs cross into clk through two flops
  assign bus_raw.addr       = std_addr;
  assign bus_raw.data       = std_data_in;
  assign bus_raw.rd_n       = std_rd_n;
  assign bus_raw.wr_n       = std_wr_n;
  assign bus_raw.memrq_n    = std_memrq_n;
  assign bus_raw.iorq_n     = std_iorq_n;
  assign bus_raw.memex      = std_memex;
  assign bus_raw.ioexp      = std_ioexp;
  assign bus_raw.refresh_n  = std_refresh_n;
  assign bus_raw.sysreset_n = std_sysreset_n;

  // strobes idle high so a reset does not fake a cycle
  bms_sync #(
    .WIDTH     (BUS_W),
    .RESET_VAL (64'h0000_0000_0000_00f3)
  ) u_bus_sync (
    .clk      (clk),
    .resetn   (resetn),
    .async_in (bus_raw),
    .sync_out (bus)
  );

  // configuration view of the register words
  assign cfg.port_jmp       = cfg_qual[`BMS_POS_PORT_JMP +: 8];
  assign cfg.ioexp_mode     = bms_pkg::bms_qual_t'(cfg_qual[`BMS_POS_IOEXP_MODE +: 2]);
  assign cfg.memex_mode     = bms_pkg::bms_qual_t'(cfg_qual[`BMS_POS_MEMEX_MODE +: 2]);
  assign cfg.common_onboard = cfg_qual[`BMS_POS_COMMON_ON];
  assign cfg.boot_on_reset  = cfg_qual[`BMS_POS_BOOT_ON];
  assign cfg.row_bank       = {cfg_rows[`BMS_POS_ROW_FIELD + `BMS_ROW_FIELD_W +: 3],
                               cfg_rows[`BMS_POS_ROW_FIELD +: 3]};
  assign cfg.row_present    = {cfg_rows[`BMS_POS_ROW_FIELD + `BMS_ROW_FIELD_W + 3],
                               cfg_rows[`BMS_POS_ROW_FIELD + 3]};
  assign cfg.start_jmp      = cfg_rows[`BMS_POS_START_JMP +: 8];
  assign cfg.end_jmp        = cfg_rows[`BMS_POS_END_JMP +: 8];
  assign present            = cfg.row_present[NUM_ROWS-1:0];

  // apb decode, zero wait states
  assign apb_access = psel && penable;
  assign apb_write  = apb_access && pwrite;
  assign hit_qual   = (paddr == `BMS_OFF_CFG_QUAL);
  assign hit_rows   = (paddr == `BMS_OFF_CFG_ROWS);
  assign hit_status = (paddr == `BMS_OFF_STATUS);
  assign hit_any    = hit_qual || hit_rows || hit_status;
  assign pready     = 1'b1;
  // unmapped address and writes to status are errors
  assign pslverr    = apb_access && (!hit_any || (pwrite && hit_status));

  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_strb
      assign strb_mask[8*b +: 8] = {8{pstrb[b]}};
    end
  endgenerate

  assign status_word = {{(32 - `BMS_POS_ST_ROW_EN - NUM_ROWS){1'b0}},
                        row_enable,
                        1'b0,
                        board_ok,
                        in_common,
                        boot_active,
                        bank};

  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
      if (hit_qual) begin
        prdata = cfg_qual;
      end else if (hit_rows) begin
        prdata = cfg_rows;
      end else if (hit_status) begin
        prdata = status_word;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_qual <= `BMS_RST_CFG_QUAL;
      cfg_rows <= `BMS_RST_CFG_ROWS;
    end else if (apb_write && hit_qual) begin
      cfg_qual <= (cfg_qual & ~(strb_mask & `BMS_MASK_CFG_QUAL)) |
                  (pwdata & strb_mask & `BMS_MASK_CFG_QUAL);
    end else if (apb_write && hit_rows) begin
      cfg_rows <= (cfg_rows & ~(strb_mask & `BMS_MASK_CFG_ROWS)) |
                  (pwdata & strb_mask & `BMS_MASK_CFG_ROWS);
    end
  end

  assign port_addr   = bms_pkg::bms_jumper_value(cfg.port_jmp);
  assign io_wr       = !bus.iorq_n && !bus.wr_n;
  assign io_wr_start = io_wr && !io_wr_q;
  assign port_qual   = bms_pkg::bms_qual_ok(cfg.ioexp_mode, bus.ioexp);
  assign port_write  = io_wr_start && port_qual && (bus.addr[7:0] == port_addr);
  assign sys_reset   = !bus.sysreset_n;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      io_wr_q <= 1'b0;
    end else begin
      io_wr_q <= io_wr;
    end
  end

  // bank port holds the written byte as is
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bank <= `BMS_RST_BANK;
    end else if (sys_reset) begin
      bank <= `BMS_RST_BANK;
    end else if (port_write) begin
      bank <= bus.data;
    end
  end

  // boot hold; system reset wins over a port write
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      boot_active <= 1'b0;
    end else if (sys_reset) begin
      boot_active <= cfg.boot_on_reset;
    end else if (port_write) begin
      boot_active <= 1'b0;
    end
  end

  // memory cycle classes; refresh is never a data cycle
  assign refresh_cycle = !bus.refresh_n;
  assign mem_cycle     = !bus.memrq_n && bus.refresh_n;
  assign mem_read      = mem_cycle && !bus.rd_n;
  assign mem_write     = mem_cycle && !bus.wr_n;

  bms_row_decode #(
    .NUM_ROWS  (NUM_ROWS),
    .BANK_BITS (BANK_BITS)
  ) u_decode (
    .cfg         (cfg),
    .bank        (bank),
    .boot_active (boot_active),
    .addr        (bus.addr),
    .mem_cycle   (mem_cycle),
    .memex       (bus.memex),
    .row_hit     (row_hit),
    .in_common   (in_common),
    .board_ok    (board_ok)
  );

  assign next_row_enable  = row_hit;
  assign next_row_write   = row_hit & {NUM_ROWS{mem_write}};
  // refresh every fitted row, bank ignored
  assign next_row_refresh = present & {NUM_ROWS{refresh_cycle}};
  // drive data only on a decoded read
  assign next_data_oe     = mem_read && (|row_hit);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      row_enable  <= '0;
      row_write   <= '0;
      row_refresh <= '0;
      std_data_oe <= 1'b0;
    end else begin
      row_enable  <= next_row_enable;
      row_write   <= next_row_write;
      row_refresh <= next_row_refresh;
      std_data_oe <= next_data_oe;
    end
  end

  // row data registered both ways; costs one cycle of latency
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q   <= 8'h00;
      row_wdata <= 8'h00;
    end else begin
      rdata_q   <= row_rdata;
      row_wdata <= bus.data;
    end
  end

  assign std_data_out = rdata_q;

  assign std_intrq_n_out = 1'b1;
  assign std_intrq_n_oe  = 1'b0;

endmodule : bms_top

// ---- common/bms_consts.svh ----
`ifndef BMS_CONSTS_SVH
`define BMS_CONSTS_SVH

// register byte offsets
`define BMS_OFF_CFG_QUAL      8'h00
`define BMS_OFF_CFG_ROWS      8'h04
`define BMS_OFF_STATUS        8'h08

// qualifier register fields
`define BMS_POS_PORT_JMP      0
`define BMS_POS_IOEXP_MODE    8
`define BMS_POS_MEMEX_MODE    10
`define BMS_POS_COMMON_ON     12
`define BMS_POS_BOOT_ON       13
`define BMS_MASK_CFG_QUAL     32'h0000_3fff

// row register fields
`define BMS_POS_ROW_FIELD     0
`define BMS_ROW_FIELD_W       4
`define BMS_POS_START_JMP     8
`define BMS_POS_END_JMP       16
`define BMS_MASK_CFG_ROWS     32'h00ff_ffff

// status register fields
`define BMS_POS_ST_BANK       0
`define BMS_POS_ST_BOOT       8
`define BMS_POS_ST_COMMON     9
`define BMS_POS_ST_BOARD      10
`define BMS_POS_ST_ROW_EN     12

// reset values: every jumper open, qualifiers ignored, no rows fitted
`define BMS_RST_CFG_QUAL      32'h0000_0000
`define BMS_RST_CFG_ROWS      32'h0000_0000
`define BMS_RST_BANK          8'h00

// synchroniser depth
`define BMS_SYNC_STAGES       2

`endif

// ---- common/bms_pkg.sv ----
package bms_pkg;

  typedef enum logic [1:0] {
    BMS_QUAL_IGNORE = 2'b00,
    BMS_QUAL_LOW    = 2'b01,
    BMS_QUAL_HIGH   = 2'b10,
    BMS_QUAL_SPARE  = 2'b11
  } bms_qual_t;

  typedef struct packed {
    logic [7:0] end_jmp;
    logic [7:0] start_jmp;
    logic [1:0] row_present;
    logic [5:0] row_bank;
    logic [7:0] port_jmp;
    bms_qual_t  ioexp_mode;
    bms_qual_t  memex_mode;
    logic       common_onboard;
    logic       boot_on_reset;
  } bms_cfg_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic        rd_n;
    logic        wr_n;
    logic        memrq_n;
    logic        iorq_n;
    logic        memex;
    logic        ioexp;
    logic        refresh_n;
    logic        sysreset_n;
  } bms_bus_t;

  // jumper-in reads 0, so the value is the inverse of the jumper set
  function automatic logic [7:0] bms_jumper_value(input logic [7:0] jumpers);
    bms_jumper_value = ~jumpers;
  endfunction : bms_jumper_value

  function automatic logic bms_qual_ok(input bms_qual_t mode, input logic level);
    case (mode)
      BMS_QUAL_LOW:  bms_qual_ok = ~level;
      BMS_QUAL_HIGH: bms_qual_ok = level;
      default:       bms_qual_ok = 1'b1;
    endcase
  endfunction : bms_qual_ok

endpackage : bms_pkg

// ---- core/bms_sync.sv ----
`timescale 1ns/1ps
module bms_sync #(
  parameter int          WIDTH     = 1,
  parameter logic [63:0] RESET_VAL = 64'h0000_0000_0000_0000
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  generate
    if (WIDTH < 1 || WIDTH > 64) begin : g_bad_width
      $error("bms_sync width out of range");
    end
  endgenerate

  // stage1 feeds only the second flop
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1   <= RESET_VAL[WIDTH-1:0];
      sync_out <= RESET_VAL[WIDTH-1:0];
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : bms_sync

// ---- core/bms_row_decode.sv ----
`timescale 1ns/1ps
module bms_row_decode #(
  parameter int NUM_ROWS  = 2,
  parameter int BANK_BITS = 8
) (
  // configuration and state
  input  wire bms_pkg::bms_cfg_t   cfg,
  input  wire logic [BANK_BITS-1:0] bank,
  input  wire logic                 boot_active,
  // qualified bus view
  input  wire logic [15:0]          addr,
  input  wire logic                 mem_cycle,
  input  wire logic                 memex,
  // decode results
  output logic      [NUM_ROWS-1:0]  row_hit,
  output logic                      in_common,
  output logic                      board_ok
);

  logic [7:0] start_page;
  logic [7:0] end_page;

  assign start_page = bms_pkg::bms_jumper_value(cfg.start_jmp);
  // end page, low byte all ones
  assign end_page   = bms_pkg::bms_jumper_value(cfg.end_jmp);
  // page compare covers XX00..XXFF inclusive
  assign in_common  = (addr[15:8] >= start_page) && (addr[15:8] <= end_page);
  assign board_ok   = bms_pkg::bms_qual_ok(cfg.memex_mode, memex);

  genvar r;
  generate
    for (r = 0; r < NUM_ROWS; r++) begin : g_row
      logic [2:0] sel;
      logic       bank_hit;
      assign sel = cfg.row_bank[3*r +: 3];
      // row follows its one assigned bank bit
      assign bank_hit = cfg.row_present[r] && bank[sel];
      if (r == 0) begin : g_row0
        // common range overrides bank and boot
        assign row_hit[r] = mem_cycle && board_ok &&
                            (in_common ? cfg.common_onboard : (bank_hit || boot_active));
      end else begin : g_rown
        // common range keeps other rows quiet
        assign row_hit[r] = mem_cycle && board_ok && !in_common && bank_hit;
      end
    end
  endgenerate

endmodule : bms_row_decode

// ---- verif/bms_top_assertions.sv ----
`timescale 1ns/1ps
module bms_top_assertions #(
  parameter int NUM_ROWS = 2
) (
  // clock and reset
  input wire logic                clk,
  input wire logic                resetn,
  // backplane strobes
  input wire logic                std_rd_n,
  input wire logic                std_wr_n,
  input wire logic                std_memrq_n,
  input wire logic                std_refresh_n,
  // data and interrupt pins
  input wire logic [7:0]          row_rdata,
  input wire logic [7:0]          std_data_out,
  input wire logic                std_data_oe,
  input wire logic                std_intrq_n_out,
  input wire logic                std_intrq_n_oe,
  // row controls
  input wire logic [NUM_ROWS-1:0] row_enable,
  input wire logic [NUM_ROWS-1:0] row_write,
  input wire logic [NUM_ROWS-1:0] row_refresh
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_irq_quiet: assert property (!std_intrq_n_oe && std_intrq_n_out)
    else $error("interrupt pin driven");
  a_oe_has_row: assert property (std_data_oe |-> |row_enable)
    else $error("data driven with no row");
  a_oe_on_read: assert property ($rose(std_data_oe) |-> !std_rd_n && !std_memrq_n)
    else $error("data driven outside a read");
  a_data_follow: assert property (std_data_oe |-> std_data_out == $past(row_rdata))
    else $error("read data not from rows");
  a_write_in_row: assert property ((row_write & ~row_enable) == '0)
    else $error("write to a disabled row");
  a_rows_idle: assert property (std_memrq_n [*4] |=> row_enable == '0)
    else $error("row on with no memory cycle");
  a_refresh_quiet: assert property (std_refresh_n [*4] |=> row_refresh == '0)
    else $error("refresh outside refresh cycle");
  a_refresh_excl: assert property (|row_refresh |-> row_enable == '0)
    else $error("row enabled during refresh");
endmodule : bms_top_assertions

bind bms_top bms_top_assertions #(.NUM_ROWS(NUM_ROWS)) bms_top_assertions_i (
  .clk, .resetn, .std_rd_n, .std_wr_n, .std_memrq_n, .std_refresh_n, .row_rdata,
  .std_data_out, .std_data_oe, .std_intrq_n_out, .std_intrq_n_oe, .row_enable,
  .row_write, .row_refresh
);

// ---- verif/bms_host.sv ----
`timescale 1ns/1ps
module bms_host (
  // bus clock
  input wire logic          clk,
  // backplane pins
  output bms_pkg::bms_bus_t bus
);
  // kinds: 0 read, 1 port write, 2 refresh, 3 system reset, 4 memory write
  task automatic start(input int k, input logic [15:0] a, input logic [7:0] d, input logic lvl);
    @(posedge clk);
    bus.addr       <= a;
    bus.data       <= d;
    bus.memex      <= lvl;
    bus.ioexp      <= lvl;
    bus.rd_n       <= k != 0;
    bus.wr_n       <= k != 1 && k != 4;
    bus.memrq_n    <= k == 1 || k == 3;
    bus.iorq_n     <= k != 1;
    bus.refresh_n  <= k != 2;
    bus.sysreset_n <= k != 3;
    // long enough for the synchronisers and the row register
    repeat (6) @(posedge clk);
  endtask : start
  // address and data flip on release, strobes go idle, so a stale value never passes for a driven one
  task automatic stop();
    @(posedge clk);
    bus <= {~bus.addr, ~bus.data, 8'hf3};
    repeat (2) @(posedge clk);
  endtask : stop
  initial bus = {16'h0000, 8'h00, 8'hf3};
endmodule : bms_host

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`define CHK(g, e, m) begin num_checks++; if (((g) & (m)) !== ((e) & (m))) begin failures++; \
  $display("unexpected at %0t: got %h want %h", $time, (g), (e)); end end
module tb;
  // apb and clock
  logic              clk = 1'b0;
  logic              resetn = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [31:0]       pwdata = 32'h0000_0000;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  // backplane and rows
  bms_pkg::bms_bus_t bus;
  logic [7:0]        row_rdata = 8'h00;
  logic [1:0]        rf;
  logic [1:0]        rw;
  logic [7:0]        wd;
  logic              oe;
  // bench state
  int                failures = 0;
  int                num_checks = 0;
  logic [65:0]       notes[$];
  logic [65:0]       nt;
  logic [7:0]        bank;
  logic [7:0]        eb;
  logic [1:0]        md;
  logic              lvl;
  logic              ok;
  logic [15:0]       tbl[4] = '{16'he000, 16'hefff, 16'hdfff, 16'hf000};

  bms_top bms_top_i (
    .clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb(4'hf), .prdata, .pready,
    .pslverr, .std_addr(bus.addr), .std_data_in(bus.data), .std_data_out(), .std_data_oe(oe),
    .std_rd_n(bus.rd_n), .std_wr_n(bus.wr_n), .std_memrq_n(bus.memrq_n), .std_iorq_n(bus.iorq_n),
    .std_memex(bus.memex), .std_ioexp(bus.ioexp), .std_refresh_n(bus.refresh_n),
    .std_sysreset_n(bus.sysreset_n), .std_intrq_n_out(), .std_intrq_n_oe(), .row_enable(),
    .row_write(rw), .row_refresh(rf), .row_wdata(wd), .row_rdata
  );
  bms_host bms_host_i (.clk, .bus);

  always #4 clk = ~clk;
  // row data moves every cycle so a late sample shows
  always @(posedge clk) row_rdata <= row_rdata + 8'h3b;

  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      nt = notes.pop_front();
      `CHK({pslverr, prdata}, nt[65:33], nt[32:0]) // apb result
    end
  end

  task automatic summarize();
    $display("%0d checks, %0d failures", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [65:0] n);
    int k;
    notes.push_back(n);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      failures++;
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0000_0000, {1'b0, e, 1'b1, m});
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, {33'h0_0000_0000, 33'h1_0000_0000});
  endtask : wr
  task automatic io(input logic [15:0] a, input logic [7:0] d, input logic l);
    bms_host_i.start(1, a, d, l);
    bms_host_i.stop();
  endtask : io
  // status read while a memory read is held on the bus
  task automatic mem(input logic [15:0] a, input logic l, input logic [7:0] b, input logic bt,
                     input logic [1:0] r);
    bms_host_i.start(0, a, 8'h00, l);
    `CHK(oe, |r, 1'b1)
    rd(8'h08, {18'h0_0000, r, 3'h0, bt, b}, 32'hffff_f9ff);
    bms_host_i.stop();
  endtask : mem

  initial begin
    void'($urandom(32'hde075a42));
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rd(8'h00, 32'h0000_0000, 32'hffff_ffff); // reset value
    rd(8'h04, 32'h0000_0000, 32'hffff_ffff); // reset value
    apb(1'b0, 8'h0c, 32'h0000_0000, {33'h1_0000_0000, 33'h1_ffff_ffff}); // unmapped
    apb(1'b1, 8'h08, 32'h0000_00ff, {33'h1_0000_0000, 33'h1_0000_0000}); // read only
    rd(8'h08, 32'h0000_0000, 32'hffff_f9ff); // bank unchanged
    // port f1, rows on banks 3 and 4, common e000 to efff on board
    wr(8'h00, 32'h0000_100e);
    wr(8'h04, 32'h0010_1fcb);
    rd(8'h04, 32'h0010_1fcb, 32'hffff_ffff); // readback
    for (int n = 0; n < 8; n++) begin
      bank = 8'h01 << n;
      lvl = 1'($urandom);
      io({8'($urandom), 8'hf1}, bank, lvl);
      io({8'h00, 8'hf1 ^ bank}, ~bank, lvl);
      mem(16'($urandom_range(16'hdfff)), lvl, bank, 1'b0, {bank[4], bank[3]}); // rows
    end
    eb = 8'h80;
    for (int i = 0; i < 8; i++) begin
      md = 2'(i >> 1);
      lvl = i[0];
      wr(8'h00, 32'h0000_100e | {20'h0_0000, md, md, 8'h00});
      // 00 and 11 ignore the level, 01 wants 0, 10 wants 1
      ok = md[0] == md[1] || md[1] == lvl;
      if (ok) eb = lvl ? 8'h08 : 8'h10;
      io(16'h00f1, lvl ? 8'h08 : 8'h10, lvl);
      mem(16'h4000, lvl, eb, 1'b0, ok ? {eb[4], eb[3]} : 2'b00); // qualifiers
    end
    wr(8'h00, 32'h0000_100e);
    io(16'h00f1, 8'h10, 1'b0);
    for (int i = 0; i < 8; i++) begin
      if (i == 4) wr(8'h00, 32'h0000_000e);
      mem(tbl[i % 4], 1'b0, 8'h10, 1'b0, i[1] ? 2'b10 : {1'b0, !i[2]}); // common
    end
    wr(8'h00, 32'h0000_200e);
    bms_host_i.start(3, 16'h0000, 8'h00, 1'b0);
    bms_host_i.stop();
    rd(8'h08, 32'h0000_0100, 32'hffff_f9ff); // boot set
    bms_host_i.start(4, 16'h0100, 8'h5a, 1'b0);
    `CHK(rw, 2'b01, 2'b11)
    `CHK(wd, 8'h5a, 8'hff)
    `CHK(oe, 1'b0, 1'b1)
    bms_host_i.stop();
    mem(16'h1234, 1'b0, 8'h00, 1'b1, 2'b01); // boot row
    mem(16'he800, 1'b0, 8'h00, 1'b1, 2'b00); // common yields
    io(16'h00f1, 8'h20, 1'b0);
    mem(16'h1234, 1'b0, 8'h20, 1'b0, 2'b00); // boot ends
    bms_host_i.start(2, 16'h0000, 8'h00, 1'b0);
    `CHK(rf, 2'b11, 2'b11) // unselected refresh
    bms_host_i.stop();
    summarize();
  end
endmodule : tb
